// ---- logic/ebt_consts.vh ----
// Constants for the emulator break, trace and trigger block
// Function
// - Switch routes pass counter to break or trace
// - Pass counter zero halts when routed to break
// - Other breaks halt at once during counting
// - Enabled stack overflow break halts on overflow
// - Optional stack underflow break halts on underflow
// - Enabled watchdog break halts on watchdog reset
// - 8K circular trace overwrites unless full-break set
// - Entry: 16 address, 16 data, 8 probes
// - Trace halt freezes capture until explicit restart
// - Rising trace-halt pin edge freezes capture
// - Three capture modes: all, first, data
// - First-only mode drops second instruction cycles
// - Data-only mode keeps table second cycles only
// - Probe levels stored, highest input as MSB
// - External break edge selectable rising or falling
// - OR mode halts on first valid break
// - AND mode needs level and internal break
// - External halt waits for fetched instruction completion
// - Trigger rests low, high at trigger address
// - 16-bit pass counter decrements on address match
// - Trace routed counter inhibits capture until zero
// - Full-break halts after 8K captured cycles
`ifndef EBT_CONSTS_VH
`define EBT_CONSTS_VH

// ==========================================
// Widths
`define EBT_ADDR_W      16
`define EBT_DATA_W      16
`define EBT_PROBE_W     8
`define EBT_ENTRY_W     40
`define EBT_PTR_W       13
`define EBT_CNT_W       14

// ==========================================
// Trace buffer size and entry layout
`define EBT_TRACE_DEPTH 14'h2000
`define EBT_ENT_ADDR_HI 39
`define EBT_ENT_ADDR_LO 24
`define EBT_ENT_DATA_HI 23
`define EBT_ENT_DATA_LO 8
`define EBT_ENT_PRB_HI  7
`define EBT_ENT_PRB_LO  0

// ==========================================
// Capture modes
`define EBT_MODE_ALL    2'h0
`define EBT_MODE_FIRST  2'h1
`define EBT_MODE_DATA   2'h2

// ==========================================
// Halt cause bit positions
`define EBT_CAUSE_W     8
`define EBT_C_INT       0
`define EBT_C_PASS      1
`define EBT_C_SOVF      2
`define EBT_C_SUNF      3
`define EBT_C_WDT       4
`define EBT_C_FULL      5
`define EBT_C_EXT       6
`define EBT_C_USER      7

// ==========================================
// Reset values
`define EBT_PASS_RST    16'h0000
`define EBT_CAUSE_RST   8'h00

`endif

// ---- logic/ebt_break_trace.v ----
// Break, trace buffer and trigger logic of the emulator
`timescale 1ns/100ps
`include "ebt_consts.vh"

module ebt_break_trace (
    input  wire                       mclk_in,            // Core instruction clock, 125 MHz
    input  wire                       rst_n_in,           // Asynchronous reset, active low
    // Core execution status, same clock
    input  wire                       cycle_valid_in,     // A core cycle executes this clock
    input  wire                       first_cycle_in,     // Cycle is first cycle of an instruction
    input  wire [`EBT_ADDR_W-1:0]     exec_addr_in,       // Program address of the cycle
    input  wire [`EBT_DATA_W-1:0]     op_data_in,         // Opcode or data word of the cycle
    input  wire                       table_write_op_in,  // Cycle belongs to a table write
    input  wire                       table_read_op_in,   // Cycle belongs to a table read
    input  wire                       addr_break_in,      // Address-match break from outside
    input  wire                       stack_ovf_in,       // Push overflowed return stack, pulse
    input  wire                       stack_unf_in,       // Return stack underflow, pulse
    input  wire                       wdt_reset_in,       // Watchdog time-out reset, pulse
    input  wire                       user_halt_in,       // Halt request from host, pulse
    input  wire                       resume_in,          // Clear halt and causes, pulse
    // Configuration
    input  wire                       pass_to_break_in,   // 1: pass counter to break, 0: trace
    input  wire                       pass_load_in,       // Load pass counter, pulse
    input  wire [`EBT_ADDR_W-1:0]     pass_load_val_in,   // Value loaded into pass counter
    input  wire [`EBT_ADDR_W-1:0]     pass_addr_in,       // Pass counter address
    input  wire                       sovf_brk_en_in,     // Stack overflow break enable
    input  wire                       sunf_brk_en_in,     // Stack underflow break enable
    input  wire                       wdt_brk_en_in,      // Watchdog break enable
    input  wire                       full_brk_en_in,     // Break on trace buffer full
    input  wire [1:0]                 trace_mode_in,      // Capture mode
    input  wire                       trace_halt_cmd_in,  // Freeze trace capture, pulse
    input  wire                       trace_start_cmd_in, // Restart trace capture, pulse
    input  wire                       ext_brk_en_in,      // External break enable
    input  wire                       ext_and_mode_in,    // 1: AND with internal, 0: OR
    input  wire                       ext_falling_in,     // 1: falling edge / low level
    input  wire                       trig_en_in,         // Trigger output enable
    input  wire [`EBT_ADDR_W-1:0]     trig_lo_in,         // Trigger range low address
    input  wire [`EBT_ADDR_W-1:0]     trig_hi_in,         // Trigger range high address
    input  wire [`EBT_PTR_W-1:0]      trace_rd_addr_in,   // Trace buffer read address
    // Logic probe pins, asynchronous
    input  wire                       ext_break_in,       // External break probe
    input  wire                       trace_halt_in,      // External trace halt probe
    input  wire [`EBT_PROBE_W-1:0]    ext_trace_in,       // Trace probes, bit 0 lsb, bit 7 msb
    // Outputs
    output reg                        halt_out,           // Halt the emulated core, level
    output reg  [`EBT_CAUSE_W-1:0]    halt_cause_out,     // Sticky halt causes
    output reg                        trigger_out,        // Trigger output probe
    output reg  [`EBT_ADDR_W-1:0]     pass_count_out,     // Pass counter value
    output reg                        trace_frozen_out,   // Trace capture frozen
    output reg  [`EBT_PTR_W-1:0]      trace_wr_ptr_out,   // Next trace write slot
    output reg                        trace_full_out,     // 8K entries captured
    output reg  [`EBT_ENTRY_W-1:0]    trace_rd_data_out   // Trace entry at read address
);

// ==========================================
// Functions
function in_range;
    input [`EBT_ADDR_W-1:0] a;
    input [`EBT_ADDR_W-1:0] lo;
    input [`EBT_ADDR_W-1:0] hi;
    begin
        in_range = (a >= lo) && (a <= hi);
    end
endfunction

// ==========================================
// Pin synchronisers
reg  [`EBT_PROBE_W-1:0]  prb_s1_reg;
reg  [`EBT_PROBE_W-1:0]  prb_s2_reg;
reg                      brk_s1_reg;
reg                      brk_s2_reg;
reg                      brk_d_reg;
reg                      th_s1_reg;
reg                      th_s2_reg;
reg                      th_d_reg;

always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        prb_s1_reg <= 8'h00;
        prb_s2_reg <= 8'h00;
        brk_s1_reg <= 1'b0;
        brk_s2_reg <= 1'b0;
        brk_d_reg  <= 1'b0;
        th_s1_reg  <= 1'b0;
        th_s2_reg  <= 1'b0;
        th_d_reg   <= 1'b0;
    end else begin
        prb_s1_reg <= ext_trace_in;
        prb_s2_reg <= prb_s1_reg;
        brk_s1_reg <= ext_break_in;
        brk_s2_reg <= brk_s1_reg;
        brk_d_reg  <= brk_s2_reg;
        th_s1_reg  <= trace_halt_in;
        th_s2_reg  <= th_s1_reg;
        th_d_reg   <= th_s2_reg;
    end
end

// ==========================================
// Instruction boundary and capture qualification
wire instr_exec;
wire data_cycle;
reg  mode_hit;

assign instr_exec = cycle_valid_in & first_cycle_in;
assign data_cycle = cycle_valid_in & ~first_cycle_in & (table_write_op_in | table_read_op_in);

always @* begin
    case (trace_mode_in)
        `EBT_MODE_ALL:   mode_hit = cycle_valid_in;
        `EBT_MODE_FIRST: mode_hit = instr_exec;
        `EBT_MODE_DATA:  mode_hit = data_cycle;
        default:         mode_hit = 1'b0;
    endcase
end

// ==========================================
// Pass counter
reg  [`EBT_ADDR_W-1:0]  pass_cnt_reg;
reg  [`EBT_ADDR_W-1:0]  pass_cnt_next;
wire                    pass_hit;
wire                    pass_expire;
wire                    pass_zero;

assign pass_zero   = (pass_cnt_reg == `EBT_PASS_RST);
assign pass_hit    = instr_exec & in_range(exec_addr_in, pass_addr_in, pass_addr_in) & ~pass_zero;
assign pass_expire = pass_hit & (pass_cnt_reg == 16'h0001);

always @* begin
    pass_cnt_next = pass_cnt_reg;
    if (pass_load_in) begin
        pass_cnt_next = pass_load_val_in;
    end else if (pass_hit & ~halt_out) begin
        pass_cnt_next = pass_cnt_reg - 16'h0001;
    end
end

always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        pass_cnt_reg   <= `EBT_PASS_RST;
        pass_count_out <= `EBT_PASS_RST;
    end else begin
        pass_cnt_reg   <= pass_cnt_next;
        pass_count_out <= pass_cnt_next;
    end
end

// ==========================================
// Trace capture
reg  [`EBT_ENTRY_W-1:0]  trace_mem [0:`EBT_TRACE_DEPTH-1];
reg  [`EBT_PTR_W-1:0]    wr_ptr_reg;
reg  [`EBT_CNT_W-1:0]    cap_cnt_reg;
reg                      frozen_reg;
wire                     pass_gate;
wire                     capture;
wire                     buf_full;
wire                     th_rise;

assign th_rise   = th_s2_reg & ~th_d_reg;
// Counter routed to trace holds capture off until it reaches zero
assign pass_gate = pass_to_break_in | pass_zero;
assign buf_full  = (cap_cnt_reg == `EBT_TRACE_DEPTH);
// A full buffer with the full-break selected stops writing instead of wrapping
assign capture   = mode_hit & pass_gate & ~frozen_reg & ~halt_out
                 & ~(full_brk_en_in & buf_full);

always @(posedge mclk_in) begin
    if (capture) begin
        trace_mem[wr_ptr_reg] <= {exec_addr_in, op_data_in, prb_s2_reg};
    end
    trace_rd_data_out <= trace_mem[trace_rd_addr_in];
end

always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        wr_ptr_reg       <= 13'h0000;
        cap_cnt_reg      <= 14'h0000;
        frozen_reg       <= 1'b0;
        trace_frozen_out <= 1'b0;
        trace_wr_ptr_out <= 13'h0000;
        trace_full_out   <= 1'b0;
    end else begin
        if (capture) begin
            wr_ptr_reg <= wr_ptr_reg + 13'h0001;
            if (!buf_full) begin
                cap_cnt_reg <= cap_cnt_reg + 14'h0001;
            end
        end
        // Freeze wins over a restart in the same cycle
        if (trace_halt_cmd_in | th_rise) begin
            frozen_reg       <= 1'b1;
            trace_frozen_out <= 1'b1;
        end else if (trace_start_cmd_in) begin
            frozen_reg       <= 1'b0;
            trace_frozen_out <= 1'b0;
        end
        trace_wr_ptr_out <= capture ? wr_ptr_reg + 13'h0001 : wr_ptr_reg;
        trace_full_out   <= buf_full | (capture & (cap_cnt_reg == 14'h1fff));
    end
end

// ==========================================
// Break logic
reg                      ext_pend_reg;
wire                     ext_edge;
wire                     ext_level;
wire [`EBT_CAUSE_W-1:0]  int_causes;
wire                     int_any;
wire                     ext_or;
wire                     ext_and;
wire                     halt_set;
wire [`EBT_CAUSE_W-1:0]  cause_set;

assign ext_edge  = ext_falling_in ? (brk_d_reg & ~brk_s2_reg)
                                  : (~brk_d_reg & brk_s2_reg);
assign ext_level = ext_falling_in ? ~brk_s2_reg : brk_s2_reg;

assign int_causes[`EBT_C_INT]  = addr_break_in;
assign int_causes[`EBT_C_PASS] = pass_to_break_in & pass_expire;
assign int_causes[`EBT_C_SOVF] = sovf_brk_en_in & stack_ovf_in;
assign int_causes[`EBT_C_SUNF] = sunf_brk_en_in & stack_unf_in;
assign int_causes[`EBT_C_WDT]  = wdt_brk_en_in & wdt_reset_in;
assign int_causes[`EBT_C_FULL] = full_brk_en_in & capture
                               & (cap_cnt_reg == 14'h1fff);
assign int_causes[`EBT_C_EXT]  = 1'b0;
assign int_causes[`EBT_C_USER] = 1'b0;
assign int_any = |int_causes;

// OR mode: an edge arms a pending halt taken at the next instruction start
assign ext_or  = ext_brk_en_in & ~ext_and_mode_in & ext_pend_reg & instr_exec;
assign ext_and = ext_brk_en_in & ext_and_mode_in & ext_level & int_any;

// In AND mode an internal break alone does not halt
assign cause_set = (ext_brk_en_in & ext_and_mode_in)
                 ? (ext_and ? (int_causes | 8'h40) : 8'h00)
                 : (int_causes | {1'b0, ext_or, 6'h00});
assign halt_set  = (|cause_set) | user_halt_in;

always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        ext_pend_reg   <= 1'b0;
        halt_out       <= 1'b0;
        halt_cause_out <= `EBT_CAUSE_RST;
    end else begin
        if (ext_or | resume_in | ~ext_brk_en_in | ext_and_mode_in) begin
            ext_pend_reg <= 1'b0;
        end
        if (ext_edge & ext_brk_en_in & ~ext_and_mode_in & ~halt_out) begin
            ext_pend_reg <= 1'b1;
        end
        // A new break in the resume cycle wins over the clear
        if (halt_set) begin
            halt_out       <= 1'b1;
            halt_cause_out <= (resume_in ? 8'h00 : halt_cause_out) | cause_set
                            | {user_halt_in, 7'h00};
        end else if (resume_in) begin
            halt_out       <= 1'b0;
            halt_cause_out <= `EBT_CAUSE_RST;
        end
    end
end

// ==========================================
// Trigger output
always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        trigger_out <= 1'b0;
    end else if (!trig_en_in) begin
        trigger_out <= 1'b0;
    end else if (instr_exec) begin
        // Level holds between instruction starts, so a range gives one pulse
        trigger_out <= in_range(exec_addr_in, trig_lo_in, trig_hi_in);
    end
end

endmodule // ebt_break_trace

// ---- verif/ebt_probe_model.sv ----
// Target-side probe model driving the break, trace-halt and trace probe pins
`timescale 1ns/100ps

module ebt_probe_model (
    input  wire       mclk_in,            // Clock
    input  wire       brk_req_in,         // Break pin level wanted
    input  wire       thalt_req_in,       // Trace-halt pin level wanted
    input  wire       xtrig_en_in,        // Loop trigger into break pin
    input  wire       trigger_in,         // Trigger from emulator
    input  wire [7:0] probe_req_in,       // Probe levels wanted
    output reg        ext_break_out = 0,  // Break pin
    output reg        trace_halt_out = 0, // Trace-halt pin
    output reg  [7:0] ext_trace_out = 0   // Probe pins, bit 7 msb
);
// ========
// Pin drive, changed just after the clock edge
always @(posedge mclk_in) begin
    ext_break_out  <= xtrig_en_in ? trigger_in : brk_req_in;
    trace_halt_out <= thalt_req_in;
    ext_trace_out  <= probe_req_in;
end
endmodule // ebt_probe_model

// ---- verif/ebt_break_trace_monitor.sv ----
// Assertion checker for the break, trace and trigger block
`timescale 1ns/100ps
`include "ebt_consts.vh"

module ebt_break_trace_monitor (
    input wire                    mclk_in,            // Clock
    input wire                    rst_n_in,           // Reset
    input wire                    cycle_valid_in,     // Core cycle
    input wire                    first_cycle_in,     // First cycle
    input wire [`EBT_ADDR_W-1:0]  exec_addr_in,       // Address
    input wire                    stack_ovf_in,       // Overflow
    input wire                    resume_in,          // Resume
    input wire                    sovf_brk_en_in,     // Overflow enable
    input wire                    ext_brk_en_in,      // External enable
    input wire                    pass_to_break_in,   // Pass routing
    input wire                    full_brk_en_in,     // Full break
    input wire [1:0]              trace_mode_in,      // Mode
    input wire                    trace_halt_cmd_in,  // Freeze
    input wire                    trace_start_cmd_in, // Restart
    input wire                    trig_en_in,         // Trigger enable
    input wire [`EBT_ADDR_W-1:0]  trig_lo_in,         // Range low
    input wire [`EBT_ADDR_W-1:0]  trig_hi_in,         // Range high
    input wire                    halt_out,           // Halt
    input wire [`EBT_CAUSE_W-1:0] halt_cause_out,     // Causes
    input wire                    trigger_out,        // Trigger
    input wire                    trace_frozen_out,   // Frozen
    input wire [`EBT_PTR_W-1:0]   trace_wr_ptr_out    // Write slot
);
// ========
// Properties
wire in_rng = exec_addr_in >= trig_lo_in && exec_addr_in <= trig_hi_in;
default clocking @(posedge mclk_in); endclocking
default disable iff (!rst_n_in);
sequence s_cause(int b);
    halt_out && halt_cause_out[b];
endsequence
sequence s_ovf_event;
    stack_ovf_in && sovf_brk_en_in && !ext_brk_en_in;
endsequence
a_ovf_halt: assert property (s_ovf_event |=> s_cause(`EBT_C_SOVF))
    else $error("overflow did not halt");
a_cause_sticky: assert property (s_cause(`EBT_C_SOVF) ##0 !resume_in |=> s_cause(`EBT_C_SOVF))
    else $error("halt cause dropped");
a_trig_range: assert property (cycle_valid_in && first_cycle_in && trig_en_in && !halt_out
    |=> trigger_out == $past(in_rng)) else $error("trigger not tracking range");
a_trig_rest: assert property (!trig_en_in ##1 !trig_en_in |-> !trigger_out)
    else $error("trigger high while disabled");
a_freeze_cmd: assert property (trace_halt_cmd_in |=> trace_frozen_out)
    else $error("freeze command ignored");
a_frozen_hold: assert property (trace_frozen_out && !trace_start_cmd_in |=> trace_frozen_out)
    else $error("capture restarted by itself");
a_ptr_idle: assert property (!cycle_valid_in || trace_frozen_out && !trace_start_cmd_in
    |=> $stable(trace_wr_ptr_out)) else $error("capture without valid cycle");
a_all_step: assert property (cycle_valid_in && trace_mode_in == `EBT_MODE_ALL && !halt_out
    && !trace_frozen_out && pass_to_break_in && !full_brk_en_in
    |=> trace_wr_ptr_out == $past(trace_wr_ptr_out) + 1'b1) else $error("cycle not captured");
endmodule // ebt_break_trace_monitor

bind ebt_break_trace ebt_break_trace_monitor u_monitor (.*);

// ---- verif/ebt_break_trace_bench.sv ----
// Self-checking bench for the break, trace and trigger block
`timescale 1ns/100ps
`include "ebt_consts.vh"

module ebt_break_trace_bench;
reg         mclk_in = 0, rst_n_in = 0, cycle_valid_in = 0, first_cycle_in = 0, brk_req = 0;
reg         table_write_op_in = 0, table_read_op_in = 0, stack_ovf_in = 0, stack_unf_in = 0;
reg         wdt_reset_in = 0, resume_in = 0, pass_load_in = 0, trace_halt_cmd_in = 0, thalt_req = 0;
reg         trace_start_cmd_in = 0, pass_to_break_in = 1, sovf_brk_en_in = 1, sunf_brk_en_in = 1;
reg         wdt_brk_en_in = 1, full_brk_en_in = 0, ext_brk_en_in = 0, ext_and_mode_in = 0;
reg         ext_falling_in = 0, trig_en_in = 0, xtrig_en = 0;
reg  [15:0] exec_addr_in = 0, op_data_in = 0, pass_load_val_in = 16'h0002, pass_addr_in = 16'h0500;
reg  [15:0] trig_lo_in = 16'h0800, trig_hi_in = 16'h0802;
reg  [12:0] trace_rd_addr_in = 0;
reg  [1:0]  trace_mode_in = `EBT_MODE_ALL;
reg         addr_break_in = 0, user_halt_in = 0;
wire        ext_break_in, trace_halt_in, halt_out, trigger_out, trace_frozen_out, trace_full_out;
wire [7:0]  ext_trace_in, halt_cause_out;
wire [15:0] pass_count_out;
wire [12:0] trace_wr_ptr_out;
wire [39:0] trace_rd_data_out;
int         bad_count = 0, checks_done = 0, i, j;
// ========
// Harness and access tasks
always #4 mclk_in = ~mclk_in;
ebt_break_trace u_dut (.*);
ebt_probe_model u_probe (.mclk_in(mclk_in), .brk_req_in(brk_req), .thalt_req_in(thalt_req),
    .xtrig_en_in(xtrig_en), .trigger_in(trigger_out), .probe_req_in(8'hC1),
    .ext_break_out(ext_break_in), .trace_halt_out(trace_halt_in), .ext_trace_out(ext_trace_in));
task automatic complete_run;
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
endtask
task automatic chk(input [39:0] s, input [39:0] e);
    checks_done++;
    if (s !== e) begin
        bad_count++;
        $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
endtask
// Pulse bits: load, resume, freeze, restart, overflow, underflow, watchdog
task automatic step(input bit v, input bit f, input [15:0] a, input [1:0] t, input [6:0] p);
    @(posedge mclk_in);
    cycle_valid_in <= v;
    first_cycle_in <= f;
    exec_addr_in <= a;
    op_data_in <= ~a;
    {table_write_op_in, table_read_op_in} <= t;
    {pass_load_in, resume_in, trace_halt_cmd_in, trace_start_cmd_in} <= p[6:3];
    {stack_ovf_in, stack_unf_in, wdt_reset_in} <= p[2:0];
endtask
task automatic idle(input int n);
    repeat (n) step(0, 0, 0, 0, 0);
endtask
task automatic sn;
    @(negedge mclk_in);
endtask
task automatic rd(input [12:0] x, input [15:0] a);
    @(posedge mclk_in);
    trace_rd_addr_in <= x;
    @(posedge mclk_in);
    sn;
    chk(trace_rd_data_out, {a, ~a, 8'hC1});
    @(posedge mclk_in);
endtask
task automatic waitb(input int n, input [15:0] a);
    for (j = 0; j < n && halt_out !== 1'b1; j++) begin
        step(1, 1, a, 0, 0);
        sn;
    end
    if (halt_out !== 1'b1) begin
        bad_count++;
        complete_run;
    end else begin
        step(0, 0, 0, 0, 0);
    end
endtask
// ========
// Scenarios
initial begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1;
    idle(1); sn;
    chk({halt_out, trigger_out, trace_frozen_out, trace_wr_ptr_out}, 0);
    step(1, 1, 16'h0100, 0, 0);
    step(1, 0, 16'h0101, 0, 0);
    idle(1); sn;
    chk(trace_wr_ptr_out, 2);
    rd(0, 16'h0100);
    rd(1, 16'h0101);
    trace_mode_in <= `EBT_MODE_FIRST;
    step(1, 1, 16'h0200, 0, 0);
    step(1, 0, 16'h0201, 0, 0);
    step(1, 1, 16'h0202, 0, 0);
    idle(1);
    trace_mode_in <= `EBT_MODE_DATA;
    sn;
    chk(trace_wr_ptr_out, 4);
    rd(3, 16'h0202);
    step(1, 1, 16'h0300, 2'b01, 0);
    step(1, 0, 16'h0301, 2'b01, 0);
    step(1, 0, 16'h0302, 2'b00, 0);
    step(1, 1, 16'h0303, 2'b10, 0);
    step(1, 0, 16'h0304, 2'b10, 0);
    idle(1);
    trace_mode_in <= `EBT_MODE_ALL;
    sn;
    chk(trace_wr_ptr_out, 6);
    rd(4, 16'h0301);
    rd(5, 16'h0304);
    step(0, 0, 0, 0, 7'h10);
    step(1, 1, 16'h0400, 0, 0);
    step(0, 0, 0, 0, 7'h10);
    step(1, 1, 16'h0401, 0, 0);
    idle(1); sn;
    chk({trace_frozen_out, trace_wr_ptr_out}, {1'b1, 13'h0006});
    step(0, 0, 0, 0, 7'h08);
    step(1, 1, 16'h0402, 0, 0);
    idle(1); sn;
    chk({trace_frozen_out, trace_wr_ptr_out}, {1'b0, 13'h0007});
    rd(6, 16'h0402);
    thalt_req <= 1;
    idle(6); sn;
    chk({trace_frozen_out, halt_out}, 2'b10);
    step(0, 0, 0, 0, 7'h08);
    for (i = 0; i < 3; i++) begin
        step(0, 0, 0, 0, 7'(1 << i));
        idle(2); sn;
        chk({halt_out, halt_cause_out}, {1'b1, 8'h10 >> i});
        step(0, 0, 0, 0, 7'h20);
        idle(1); sn;
        chk({halt_out, halt_cause_out}, 0);
    end
    step(0, 0, 0, 0, 0);
    {addr_break_in, user_halt_in} <= 2'b10;
    step(0, 0, 0, 0, 0);
    {addr_break_in, user_halt_in} <= 2'b01;
    step(0, 0, 0, 0, 0);
    {addr_break_in, user_halt_in} <= 2'b00;
    idle(1); sn;
    chk({halt_out, halt_cause_out}, {1'b1, 8'h81});
    step(0, 0, 0, 0, 7'h20);
    step(0, 0, 0, 0, 7'h04);
    sovf_brk_en_in <= 0;
    idle(2);
    sovf_brk_en_in <= 1;
    sn;
    chk(halt_out, 0);
    step(0, 0, 0, 0, 7'h40);
    idle(1); sn;
    chk(pass_count_out, 2);
    step(1, 1, 16'h0500, 0, 0);
    idle(1); sn;
    chk({halt_out, pass_count_out}, 1);
    step(0, 0, 0, 0, 7'h04);
    idle(2); sn;
    chk({halt_out, halt_cause_out, pass_count_out}, {1'b1, 8'h04, 16'h0001});
    step(0, 0, 0, 0, 7'h20);
    step(1, 1, 16'h0500, 0, 0);
    idle(2); sn;
    chk({halt_out, halt_cause_out, pass_count_out}, {1'b1, 8'h02, 16'h0000});
    step(0, 0, 0, 0, 7'h20);
    pass_to_break_in <= 0;
    pass_load_val_in <= 16'h0001;
    step(0, 0, 0, 0, 7'h40);
    step(1, 1, 16'h0600, 0, 0);
    step(1, 1, 16'h0500, 0, 0);
    step(1, 1, 16'h0601, 0, 0);
    idle(1);
    pass_to_break_in <= 1;
    sn;
    chk(trace_wr_ptr_out, 10);
    rd(9, 16'h0601);
    for (i = 0; i < 2; i++) begin
        ext_falling_in <= i[0];
        brk_req <= i[0];
        idle(4);
        ext_brk_en_in <= 1;
        idle(2);
        brk_req <= !i[0];
        idle(6); sn;
        chk(halt_out, 0);
        waitb(8, 16'h0700);
        chk(halt_cause_out[`EBT_C_EXT], 1);
        step(0, 0, 0, 0, 7'h20);
        ext_brk_en_in <= 0;
    end
    idle(2);
    ext_and_mode_in <= 1;
    ext_falling_in <= 0;
    ext_brk_en_in <= 1;
    idle(4);
    step(0, 0, 0, 0, 7'h04);
    idle(2);
    brk_req <= 1;
    sn;
    chk(halt_out, 0);
    idle(4);
    step(0, 0, 0, 0, 7'h04);
    idle(2); sn;
    chk({halt_out, halt_cause_out[`EBT_C_SOVF]}, 2'b11);
    step(0, 0, 0, 0, 7'h20);
    ext_brk_en_in <= 0;
    ext_and_mode_in <= 0;
    brk_req <= 0;
    trig_en_in <= 1;
    step(1, 1, 16'h0801, 0, 0);
    step(1, 0, 16'h0801, 0, 0);
    idle(2); sn;
    chk(trigger_out, 1);
    step(1, 1, 16'h0802, 0, 0);
    idle(3); sn;
    chk(trigger_out, 1);
    step(1, 1, 16'h0803, 0, 0);
    idle(1);
    xtrig_en <= 1;
    ext_brk_en_in <= 1;
    sn;
    chk(trigger_out, 0);
    step(1, 1, 16'h0800, 0, 0);
    waitb(10, 16'h0700);
    chk(halt_cause_out[`EBT_C_EXT], 1);
    step(0, 0, 0, 0, 7'h20);
    xtrig_en <= 0;
    ext_brk_en_in <= 0;
    full_brk_en_in <= 1;
    idle(1); sn;
    waitb(8300, 16'h0700);
    sn;
    chk({halt_out, halt_cause_out[`EBT_C_FULL], trace_full_out, trace_wr_ptr_out}, {3'b111, 13'h0000});
    step(0, 0, 0, 0, 7'h20);
    full_brk_en_in <= 0;
    step(1, 1, 16'h0900, 0, 0);
    idle(1); sn;
    chk(trace_wr_ptr_out, 1);
    rd(0, 16'h0900);
    complete_run;
end
endmodule // ebt_break_trace_bench
